// ### inc/crs_consts.svh
/*
  Constants for the CAN port rate selector and status lamp block.
  Assumes inclusion by bare name from the package and the design files.
*/
`ifndef CRS_CONSTS_SVH
`define CRS_CONSTS_SVH

`define CRS_PORTS           4
`define CRS_SEL_W           4
`define CRS_RATE_W          14
// ----------------------------------------------------------------
// Selector codes
// ----------------------------------------------------------------
`define CRS_SEL_LAST_FIXED  4'hc
`define CRS_SEL_USER        4'hd
// ----------------------------------------------------------------
// Bit rates in units of 0.1 kbps
// ----------------------------------------------------------------
`define CRS_RATE_5K         14'h0032
`define CRS_RATE_10K        14'h0064
`define CRS_RATE_20K        14'h00c8
`define CRS_RATE_33K3       14'h014d
`define CRS_RATE_50K        14'h01f4
`define CRS_RATE_62K5       14'h0271
`define CRS_RATE_83K3       14'h0341
`define CRS_RATE_100K       14'h03e8
`define CRS_RATE_125K       14'h04e2
`define CRS_RATE_250K       14'h09c4
`define CRS_RATE_500K       14'h1388
`define CRS_RATE_800K       14'h1f40
`define CRS_RATE_1M         14'h2710
`define CRS_RATE_RST        14'h0032
`define CRS_USER_RATE_RST   14'h04e2
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CRS_CLK_KHZ         200000
`define CRS_ACT_HOLD_MS     50
`define CRS_BLINK_PERIOD_MS 1000
`define CRS_ACT_HOLD_CYC    (`CRS_ACT_HOLD_MS * `CRS_CLK_KHZ)
`define CRS_BLINK_HALF_CYC  ((`CRS_BLINK_PERIOD_MS * `CRS_CLK_KHZ) / 2)

`endif

// ### inc/crs_pkg.sv
/*
  Types for the CAN port rate selector and status lamp block.
  Assumes crs_consts.svh is on the include path.
*/
`include "crs_consts.svh"
package crs_pkg;
  typedef enum logic [1:0] {
    CRS_LAMP_OFF   = 2'b00,
    CRS_LAMP_GREEN = 2'b01,
    CRS_LAMP_RED   = 2'b10,
    CRS_LAMP_BLINK = 2'b11
  } crs_lamp_t;

  typedef logic [`CRS_RATE_W-1:0] crs_rate_t;
  typedef logic [`CRS_SEL_W-1:0]  crs_sel_t;
endpackage

// ### rtl/crs_lamp.sv
/*
  One port status lamp: stretches activity and error, picks a colour.
  Assumes active and tx_err come from logic on clk; blink_on from the top.
*/
`include "crs_consts.svh"
module crs_lamp #(
  parameter int unsigned HOLD_CYC = `CRS_ACT_HOLD_CYC
) (
  input  wire logic          clk,
  input  wire logic          rst_b,
  input  wire logic          active,
  input  wire logic          tx_err,
  input  wire logic          init_mode,
  input  wire logic          blink_on,
  output logic               green_q,
  output logic               red_q,
  output crs_pkg::crs_lamp_t state_q
);
  import crs_pkg::*;

  logic [31:0] act_cnt_q, act_cnt_d;
  logic [31:0] err_cnt_q, err_cnt_d;
  crs_lamp_t   state_d;
  logic        green_d, red_d;

  always_comb begin
    act_cnt_d = (act_cnt_q != 32'h0) ? act_cnt_q - 32'h1 : 32'h0;
    err_cnt_d = (err_cnt_q != 32'h0) ? err_cnt_q - 32'h1 : 32'h0;
    if (active) begin
      act_cnt_d = 32'(HOLD_CYC);
    end
    if (tx_err) begin
      err_cnt_d = 32'(HOLD_CYC);
    end
    if (init_mode) begin
      state_d = CRS_LAMP_BLINK;
    end else if (tx_err || err_cnt_q != 32'h0) begin
      state_d = CRS_LAMP_RED;
    end else if (active || act_cnt_q != 32'h0) begin
      state_d = CRS_LAMP_GREEN;
    end else begin
      state_d = CRS_LAMP_OFF;
    end
    case (state_d)
      CRS_LAMP_OFF: begin
        green_d = 1'b0;
        red_d   = 1'b0;
      end
      CRS_LAMP_GREEN: begin
        green_d = 1'b1;
        red_d   = 1'b0;
      end
      CRS_LAMP_RED: begin
        green_d = 1'b0;
        red_d   = 1'b1;
      end
      CRS_LAMP_BLINK: begin
        green_d = blink_on;
        red_d   = 1'b0;
      end
      default: begin
        green_d = 1'b0;
        red_d   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      act_cnt_q <= 32'h0;
      err_cnt_q <= 32'h0;
      state_q   <= CRS_LAMP_OFF;
      green_q   <= 1'b0;
      red_q     <= 1'b0;
    end else begin
      act_cnt_q <= act_cnt_d;
      err_cnt_q <= err_cnt_d;
      state_q   <= state_d;
      green_q   <= green_d;
      red_q     <= red_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_dark;
    @(posedge clk) disable iff (!rst_b)
    (!init_mode && !active && !tx_err && act_cnt_q == 32'h0 && err_cnt_q == 32'h0)
      |=> (!green_q && !red_q);
  endproperty
  a_dark: assert property (p_dark) else $error("lamp lit on idle port");

  property p_green;
    @(posedge clk) disable iff (!rst_b)
    (!init_mode && active && !tx_err && err_cnt_q == 32'h0) |=> (green_q && !red_q);
  endproperty
  a_green: assert property (p_green) else $error("active port not green");

  property p_red;
    @(posedge clk) disable iff (!rst_b)
    (!init_mode && tx_err) |=> ##[0:3] (red_q && !green_q && state_q == CRS_LAMP_RED);
  endproperty
  a_red: assert property (p_red) else $error("error port not red");

  property p_prio;
    @(posedge clk) disable iff (!rst_b)
    (!init_mode && tx_err && active) |=> (red_q && !green_q);
  endproperty
  a_prio: assert property (p_prio) else $error("green beat red");

  // Valid while HOLD_CYC is 3 or more
  property p_stretch;
    @(posedge clk) disable iff (!rst_b)
    (!init_mode && active && !tx_err && err_cnt_q == 32'h0)
      ##1 (!init_mode && !active && !tx_err)[*3] |=> green_q;
  endproperty
  a_stretch: assert property (p_stretch) else $error("activity not stretched");

  property p_blink;
    @(posedge clk) disable iff (!rst_b)
    init_mode |=> (green_q == $past(blink_on) && !red_q);
  endproperty
  a_blink: assert property (p_blink) else $error("lamp not following blink");
endmodule

// ### rtl/crs_top.sv
/*
  Common bit-rate decode from a rotary selector, user rate store, mode
  handling and four port status lamps with a shared blink timer.
  Assumes rate_sel and init_sw are asynchronous pins; port_active,
  port_tx_err, cfg_wr and cfg_rate come from logic on clk.
*/
`include "crs_consts.svh"
module crs_top #(
  parameter int unsigned ACT_HOLD_CYC   = `CRS_ACT_HOLD_CYC,
  parameter int unsigned BLINK_HALF_CYC = `CRS_BLINK_HALF_CYC
) (
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  input  wire crs_pkg::crs_sel_t      rate_sel,
  input  wire logic                   init_sw,
  input  wire logic [`CRS_PORTS-1:0]  port_active,
  input  wire logic [`CRS_PORTS-1:0]  port_tx_err,
  input  wire logic                   cfg_wr,
  input  wire crs_pkg::crs_rate_t     cfg_rate,
  output crs_pkg::crs_rate_t          rate_kbps_x10_q,
  output logic                        rate_user_q,
  output logic                        rate_bad_q,
  output logic                        rate_upd_q,
  output crs_pkg::crs_rate_t          user_rate_q,
  output logic                        cfg_open_q,
  output logic                        switch_en_q,
  output logic [`CRS_PORTS-1:0]       led_green,
  output logic [`CRS_PORTS-1:0]       led_red
);
  import crs_pkg::*;

  // ----------------------------------------------------------------
  // Rate table
  // ----------------------------------------------------------------
  function automatic crs_rate_t crs_rate_of(input crs_sel_t sel);
    case (sel)
      4'h0:    crs_rate_of = `CRS_RATE_5K;
      4'h1:    crs_rate_of = `CRS_RATE_10K;
      4'h2:    crs_rate_of = `CRS_RATE_20K;
      4'h3:    crs_rate_of = `CRS_RATE_33K3;
      4'h4:    crs_rate_of = `CRS_RATE_50K;
      4'h5:    crs_rate_of = `CRS_RATE_62K5;
      4'h6:    crs_rate_of = `CRS_RATE_83K3;
      4'h7:    crs_rate_of = `CRS_RATE_100K;
      4'h8:    crs_rate_of = `CRS_RATE_125K;
      4'h9:    crs_rate_of = `CRS_RATE_250K;
      4'ha:    crs_rate_of = `CRS_RATE_500K;
      4'hb:    crs_rate_of = `CRS_RATE_800K;
      4'hc:    crs_rate_of = `CRS_RATE_1M;
      default: crs_rate_of = `CRS_RATE_RST;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  crs_sel_t sel_m_q, sel_s_q;
  logic     init_m_q, init_s_q;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sel_m_q  <= 4'h0;
      sel_s_q  <= 4'h0;
      init_m_q <= 1'b0;
      init_s_q <= 1'b0;
    end else begin
      sel_m_q  <= rate_sel;
      sel_s_q  <= sel_m_q;
      init_m_q <= init_sw;
      init_s_q <= init_m_q;
    end
  end

  // ----------------------------------------------------------------
  // Rate decode
  // ----------------------------------------------------------------
  crs_rate_t rate_d;
  logic      rate_user_d, rate_bad_d, rate_upd_d;

  always_comb begin
    rate_d      = rate_kbps_x10_q;
    rate_user_d = 1'b0;
    rate_bad_d  = 1'b0;
    if (sel_s_q <= `CRS_SEL_LAST_FIXED) begin
      rate_d = crs_rate_of(sel_s_q);
    end else if (sel_s_q == `CRS_SEL_USER) begin
      rate_d      = user_rate_q;
      rate_user_d = 1'b1;
    end else begin
      // Unsupported setting keeps the last good rate so ports stay sane
      rate_bad_d = 1'b1;
    end
    rate_upd_d = (rate_d != rate_kbps_x10_q);
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rate_kbps_x10_q <= `CRS_RATE_RST;
      rate_user_q     <= 1'b0;
      rate_bad_q      <= 1'b0;
      rate_upd_q      <= 1'b0;
    end else begin
      rate_kbps_x10_q <= rate_d;
      rate_user_q     <= rate_user_d;
      rate_bad_q      <= rate_bad_d;
      rate_upd_q      <= rate_upd_d;
    end
  end

  // ----------------------------------------------------------------
  // Mode and configuration
  // ----------------------------------------------------------------
  crs_rate_t user_rate_d;
  logic      cfg_open_d, switch_en_d;

  always_comb begin
    user_rate_d = user_rate_q;
    // Writes outside initial mode are dropped, not queued
    if (init_s_q && cfg_wr) begin
      user_rate_d = cfg_rate;
    end
    cfg_open_d  = init_s_q;
    switch_en_d = !init_s_q && !rate_bad_d;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      user_rate_q <= `CRS_USER_RATE_RST;
      cfg_open_q  <= 1'b0;
      switch_en_q <= 1'b0;
    end else begin
      user_rate_q <= user_rate_d;
      cfg_open_q  <= cfg_open_d;
      switch_en_q <= switch_en_d;
    end
  end

  // ----------------------------------------------------------------
  // Blink timer
  // ----------------------------------------------------------------
  logic [31:0] blink_cnt_q, blink_cnt_d;
  logic        blink_q, blink_d;

  always_comb begin
    blink_cnt_d = 32'h0;
    blink_d     = 1'b1;
    // Restarts on entry so every lamp begins its flash in step
    if (init_s_q) begin
      if (blink_cnt_q >= 32'(BLINK_HALF_CYC - 1)) begin
        blink_d = !blink_q;
      end else begin
        blink_cnt_d = blink_cnt_q + 32'h1;
        blink_d     = blink_q;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      blink_cnt_q <= 32'h0;
      blink_q     <= 1'b1;
    end else begin
      blink_cnt_q <= blink_cnt_d;
      blink_q     <= blink_d;
    end
  end

  // ----------------------------------------------------------------
  // Port lamps
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `CRS_PORTS; gi++) begin : g_lamp
      crs_lamp #(
        .HOLD_CYC (ACT_HOLD_CYC)
      ) u_lamp (
        .clk       (clk),
        .rst_b     (rst_b),
        .active    (port_active[gi]),
        .tx_err    (port_tx_err[gi]),
        .init_mode (init_s_q),
        .blink_on  (blink_q),
        .green_q   (led_green[gi]),
        .red_q     (led_red[gi]),
        .state_q   ()
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_fixed_map;
    @(posedge clk) disable iff (!rst_b)
    (sel_s_q <= `CRS_SEL_LAST_FIXED)
      |=> (rate_kbps_x10_q == crs_rate_of($past(sel_s_q)) && !rate_user_q && !rate_bad_q);
  endproperty
  a_fixed_map: assert property (p_fixed_map) else $error("fixed rate wrong");

  property p_user_map;
    @(posedge clk) disable iff (!rst_b)
    (sel_s_q == `CRS_SEL_USER) |=> (rate_kbps_x10_q == $past(user_rate_q) && rate_user_q);
  endproperty
  a_user_map: assert property (p_user_map) else $error("user rate not used");

  property p_bad_hold;
    @(posedge clk) disable iff (!rst_b)
    (sel_s_q > `CRS_SEL_USER) |=> (rate_bad_q && $stable(rate_kbps_x10_q) && !switch_en_q);
  endproperty
  a_bad_hold: assert property (p_bad_hold) else $error("bad selector accepted");

  property p_cfg_take;
    @(posedge clk) disable iff (!rst_b)
    (init_s_q && cfg_wr) |=> (user_rate_q == $past(cfg_rate));
  endproperty
  a_cfg_take: assert property (p_cfg_take) else $error("config write lost");

  property p_cfg_lock;
    @(posedge clk) disable iff (!rst_b)
    (!init_s_q && cfg_wr) |=> $stable(user_rate_q);
  endproperty
  a_cfg_lock: assert property (p_cfg_lock) else $error("config taken in normal");

  property p_mode_out;
    @(posedge clk) disable iff (!rst_b)
    init_s_q |=> (cfg_open_q && !switch_en_q);
  endproperty
  a_mode_out: assert property (p_mode_out) else $error("mode outputs wrong");

  property p_blink_half;
    @(posedge clk) disable iff (!rst_b)
    (init_s_q && blink_cnt_q == 32'(BLINK_HALF_CYC - 1)) |=> (blink_q != $past(blink_q));
  endproperty
  a_blink_half: assert property (p_blink_half) else $error("blink not toggled");

  c_user:  cover property (@(posedge clk) disable iff (!rst_b) rate_user_q);
  c_bad:   cover property (@(posedge clk) disable iff (!rst_b) rate_bad_q);
  c_blink: cover property (@(posedge clk) disable iff (!rst_b) cfg_open_q && $fell(blink_q));
  c_red:   cover property (@(posedge clk) disable iff (!rst_b) &led_red);
endmodule

// ### bench/crs_ctl_model.sv
/*
  Far-side model: rotary selector, mode switch and four CAN controllers.
  Assumes the bench calls its tasks just after a falling clock edge.
*/
`include "crs_consts.svh"
module crs_ctl_model (
  output crs_pkg::crs_sel_t     rate_sel,
  output logic                  init_sw,
  output logic [`CRS_PORTS-1:0] port_active,
  output logic [`CRS_PORTS-1:0] port_tx_err
);
  timeunit 1ns;
  timeprecision 100ps;
  import crs_pkg::*;

  // ----------------------------------------------------------------
  // Pin levels
  // ----------------------------------------------------------------
  // Pins are levels, so a setting simply stands until the next call
  initial begin
    rate_sel = 4'h0;
    init_sw = 1'b0;
    port_active = 4'h0;
    port_tx_err = 4'h0;
  end

  task automatic set_sel(input crs_sel_t v);
    rate_sel = v;
  endtask

  task automatic set_mode(input logic m);
    init_sw = m;
  endtask

  task automatic set_port(input logic [`CRS_PORTS-1:0] act, input logic [`CRS_PORTS-1:0] err);
    port_active = act;
    port_tx_err = err;
  endtask
endmodule

// ### bench/crs_top_test.sv
/*
  Self-checking bench for crs_top with shortened hold and blink counts.
  Assumes crs_ctl_model drives the pins; bench drives config and reset.
*/
`include "crs_consts.svh"
module crs_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  import crs_pkg::*;

  localparam int unsigned HOLD = 8;
  localparam int unsigned HALF = 4;
  logic                  clk;
  logic                  rst_b;
  crs_sel_t              rate_sel;
  logic                  init_sw;
  logic [`CRS_PORTS-1:0] port_active;
  logic [`CRS_PORTS-1:0] port_tx_err;
  logic                  cfg_wr;
  crs_rate_t             cfg_rate;
  crs_rate_t             rate_kbps_x10_q;
  logic                  rate_user_q;
  logic                  rate_bad_q;
  logic                  rate_upd_q;
  crs_rate_t             user_rate_q;
  logic                  cfg_open_q;
  logic                  switch_en_q;
  logic [`CRS_PORTS-1:0] led_green;
  logic [`CRS_PORTS-1:0] led_red;
  int                    bad_count;
  int                    check_count;
  int                    mode;
  int                    exp_rate;
  int                    exp_user;
  int                    ones;
  logic [`CRS_PORTS-1:0] act_new;
  logic [`CRS_PORTS-1:0] act_acc;
  int                    rate_tab[$] = '{50, 100, 200, 333, 500, 625, 833, 1000, 1250, 2500,
                                         5000, 8000, 10000};
  crs_rate_t             wr_vals[$];

  crs_ctl_model ctl_inst (.rate_sel(rate_sel), .init_sw(init_sw), .port_active(port_active),
                          .port_tx_err(port_tx_err));

  crs_top #(.ACT_HOLD_CYC(HOLD), .BLINK_HALF_CYC(HALF)) crs_top_inst (
    .clk(clk), .rst_b(rst_b), .rate_sel(rate_sel), .init_sw(init_sw),
    .port_active(port_active), .port_tx_err(port_tx_err), .cfg_wr(cfg_wr),
    .cfg_rate(cfg_rate), .rate_kbps_x10_q(rate_kbps_x10_q), .rate_user_q(rate_user_q),
    .rate_bad_q(rate_bad_q), .rate_upd_q(rate_upd_q), .user_rate_q(user_rate_q),
    .cfg_open_q(cfg_open_q), .switch_en_q(switch_en_q), .led_green(led_green),
    .led_red(led_red));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  // Model: E/F keep the last rate, D follows the stored user rate
  task automatic sel_step(input int v);
    int n;
    int prev;
    prev = exp_rate;
    ctl_inst.set_sel(4'(v));
    if (v <= 12) exp_rate = rate_tab[v];
    else if (v == 13) exp_rate = exp_user;
    if (exp_rate != prev) begin
      n = 0;
      while (rate_upd_q !== 1'b1 && n < 8) begin
        @(posedge clk);
        #1;
        n++;
      end
      if (rate_upd_q !== 1'b1) begin
        bad_count++;
        final_report();
      end
      @(posedge clk);
      #1;
      check(32'(rate_upd_q), 32'h0);
    end
    cycles(4);
    check(32'(rate_kbps_x10_q), 32'(exp_rate));
    check(32'(rate_user_q), 32'(v == 13));
    check(32'(rate_bad_q), 32'(v > 13));
    check(32'(switch_en_q), 32'(v < 14 && mode == 0));
  endtask

  // Writes back to back; only initial mode may keep them
  task automatic cfg_write();
    cfg_wr = 1'b1;
    foreach (wr_vals[i]) begin
      cfg_rate = wr_vals[i];
      if (mode == 1) exp_user = int'(wr_vals[i]);
      cycles(1);
    end
    cfg_wr = 1'b0;
    // Selector at D tracks the stored rate live, so the model must follow
    if (mode == 1 && rate_sel == 4'hd) exp_rate = exp_user;
    check(32'(user_rate_q), 32'(exp_user));
  endtask

  task automatic lamp_port(input int p);
    ctl_inst.set_port(4'(1 << p), 4'h0);
    cycles(1);
    check(32'(led_green), 32'(1 << p));
    ctl_inst.set_port(4'h0, 4'h0);
    cycles(HOLD - 2);
    check(32'(led_green), 32'(1 << p));
    cycles(4);
    check(32'(led_green), 32'h0);
    ctl_inst.set_port(4'(1 << p), 4'(1 << p));
    cycles(1);
    ctl_inst.set_port(4'(1 << p), 4'h0);
    check(32'(led_red), 32'(1 << p));
    check(32'(led_green), 32'h0);
    cycles(HOLD + 4);
    check(32'({led_red, led_green}), 32'(1 << p));
    ctl_inst.set_port(4'h0, 4'h0);
    cycles(HOLD + 4);
    check(32'({led_red, led_green}), 32'h0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    cfg_wr = 1'b0;
    cfg_rate = 14'h0000;
    bad_count = 0;
    check_count = 0;
    mode = 0;
    exp_rate = 50;
    exp_user = 1250;
    void'($urandom(83765));
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    check(32'(rate_kbps_x10_q), 32'(exp_rate));
    check(32'(user_rate_q), 32'(exp_user));
    check(32'({led_red, led_green, cfg_open_q, rate_bad_q}), 32'h0);
    for (int v = 0; v < 16; v++) sel_step(v);
    sel_step(7);
    sel_step(14);
    sel_step(13);
    repeat (6) sel_step(int'($urandom_range(15)));
    $display("test rate table done");

    wr_vals = '{crs_rate_t'($urandom)};
    cfg_write();
    ctl_inst.set_mode(1'b1);
    mode = 1;
    ctl_inst.set_port(4'hf, 4'hf);
    cycles(4);
    check(32'(cfg_open_q), 32'h1);
    ones = 0;
    for (int i = 0; i < 4 * HALF; i++) begin
      check(32'(led_green == 4'h0 || led_green == 4'hf), 32'h1);
      check(32'(led_red), 32'h0);
      if (led_green === 4'hf) ones++;
      cycles(1);
    end
    check(32'(ones), 32'(2 * HALF));
    ctl_inst.set_port(4'h0, 4'h0);
    $display("test blink done");

    wr_vals = '{crs_rate_t'($urandom), crs_rate_t'($urandom)};
    cfg_write();
    sel_step(13);
    wr_vals = '{crs_rate_t'($urandom)};
    cfg_write();
    exp_rate = exp_user;
    cycles(1);
    check(32'(rate_kbps_x10_q), 32'(exp_rate));
    ctl_inst.set_mode(1'b0);
    mode = 0;
    cycles(HOLD + 4);
    check(32'({cfg_open_q, led_red, led_green}), 32'h0);
    sel_step(13);
    $display("test config done");

    for (int p = 0; p < `CRS_PORTS; p++) lamp_port(p);
    act_acc = 4'h0;
    repeat (4) begin
      act_new = 4'($urandom);
      ctl_inst.set_port(act_new, 4'h0);
      // Four cycles stay inside the hold, so earlier ports are still lit
      act_acc = act_acc | act_new;
      cycles(1);
      check(32'(led_green), 32'(act_acc));
    end
    $display("test lamps done");
    final_report();
  end

  // Cuts a hang short well under the run budget
  initial begin
    repeat (50000) @(posedge clk);
    bad_count++;
    final_report();
  end
endmodule
